// *** bench/mcr_mode_ctl_sva.sv ***
// Checker for the mode-control register block.
// Assumes RD_DATA low half mirrors the register after each edge.
`timescale 1ns/1ps
module mcr_mode_ctl_sva
    import mcr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic WR_STROBE,
    input wire logic [63:0] WR_DATA,
    input wire logic TASK_SWITCH,
    input wire logic [63:0] RD_DATA,
    input wire mcr_exec_t EXEC_EVT,
    input wire mcr_fault_t FAULTS,
    input wire logic FP_EXC_PENDING,
    input wire logic FP_ERROR_IGNORE_IN,
    input wire logic FP_ERROR_OUT,
    input wire logic SUP_WRITE_RO_PAGE,
    input wire logic SUP_WRITE_BLOCK,
    input wire mcr_cache_req_t CACHE_REQ,
    input wire logic CACHE_WB_INVALIDATE
);
    // One clock domain; nothing is judged while in reset
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RST_N);
    ////////////////////////////////////////////////////////
    property p_wt; EXEC_EVT == 4'h8 |=> FAULTS[3] == ($past(RD_DATA[1]) && $past(RD_DATA[3]));
    endproperty
    a_wt: assert property (p_wt) else $error("wait fault");
    property p_em; EXEC_EVT.fp_op && RD_DATA[2] |=> FAULTS[3]; endproperty
    a_em: assert property (p_em) else $error("emul fault");
    property p_ud; EXEC_EVT.media_op |=> FAULTS[2] == $past(RD_DATA[2]); endproperty
    a_ud: assert property (p_ud) else $error("media fault");
    property p_ts; TASK_SWITCH |=> RD_DATA[3]; endproperty
    a_ts: assert property (p_ts) else $error("switch flag");
    property p_fe; FP_EXC_PENDING && !FP_ERROR_IGNORE_IN && !RD_DATA[5] |=> FP_ERROR_OUT;
    endproperty
    a_fe: assert property (p_fe) else $error("fp error out");
    property p_wp; SUP_WRITE_RO_PAGE |=> SUP_WRITE_BLOCK == $past(RD_DATA[16]); endproperty
    a_wp: assert property (p_wp) else $error("write guard");
    property p_cd; CACHE_REQ.write_hit |=> CACHE_WB_INVALIDATE == $past(RD_DATA[30]); endproperty
    a_cd: assert property (p_cd) else $error("write back");
    property p_pg; WR_STROBE && WR_DATA[31] && !WR_DATA[0]
        |=> FAULTS[1] && RD_DATA[31:4] == $past(RD_DATA[31:4]); endproperty
    a_pg: assert property (p_pg) else $error("paging fault");
endmodule : mcr_mode_ctl_sva

bind mcr_mode_ctl mcr_mode_ctl_sva u_sva (.CORE_CLK, .RST_N, .WR_STROBE, .WR_DATA,
    .TASK_SWITCH, .RD_DATA, .EXEC_EVT, .FAULTS, .FP_EXC_PENDING, .FP_ERROR_IGNORE_IN,
    .FP_ERROR_OUT, .SUP_WRITE_RO_PAGE, .SUP_WRITE_BLOCK, .CACHE_REQ, .CACHE_WB_INVALIDATE);

// *** bench/testbench.sv ***
// Self-checking bench for the mode-control register block.
// Assumes package, design and checker are compiled first.
`timescale 1ns/1ps
module testbench;
    import mcr_pkg::*;
    typedef struct packed {
        logic [63:0] rd;
        logic [6:0] pl;
        logic [5:0] lv;
    } mcr_note_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic lm = 1'b0, wr = 1'b0, clr = 1'b0, tsw = 1'b0, sup = 1'b0;
    logic af = 1'b0, pend = 1'b0, ign = 1'b0;
    logic [1:0] priv = 2'h0;
    logic ce = 1'b1, frz = 1'b0;
    logic [63:0] wd = 64'h0;
    mcr_exec_t evt = '0;
    mcr_cache_req_t creq = '0;
    logic [63:0] rd;
    mcr_fault_t flt;
    logic fpo, fpi, swb, pon, pgon, cfe, crs, cwb, pci;
    logic [63:0] m = 64'h10;
    logic [31:0] s0 = 32'h8f53c1cb, s1, s2;
    int fails = 0, compares = 0, cyc = 0;
    mcr_note_t q[$];

    mcr_mode_ctl u_mcr_mode_ctl (
        .CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(ce), .LONG_MODE(lm), .WR_STROBE(wr),
        .WR_DATA(wd), .CLEAR_SWITCHED(clr), .TASK_SWITCH(tsw), .RD_DATA(rd), .EXEC_EVT(evt),
        .ALIGN_CHECK_FLAG(af), .CURRENT_PRIVILEGE(priv), .FAULTS(flt),
        .FP_EXC_PENDING(pend), .FP_ERROR_IGNORE_IN(ign), .FP_ERROR_OUT(fpo),
        .FP_EXC_INTERNAL(fpi), .SUP_WRITE_RO_PAGE(sup), .SUP_WRITE_BLOCK(swb),
        .PROT_MODE_ON(pon), .PAGING_ON(pgon), .CACHE_REQ(creq), .CACHE_FILL_EN(cfe),
        .CACHE_READ_SERVE(crs), .CACHE_WB_INVALIDATE(cwb), .PAGE_CACHE_CTL_IGNORE(pci)
    );
    ////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic cmp_word(input logic [63:0] g, input logic [63:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_word

    task automatic cmp_bits(input logic [6:0] g, input logic [6:0] e);
        compares++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp_bits

    task automatic print_verdict;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    // One request, then a quiet cycle; r packs the side inputs
    task automatic op(input logic w, input logic [63:0] d, input logic l, input logic [31:0] r);
        logic [63:0] nd;
        logic bad;
        mcr_note_t n;
        @(posedge clk);
        nd = l ? d : {32'h0, d[31:0]};
        nd[4] = 1'b1;
        bad = w && ((l && d[63:32] != 32'h0) || (nd[31] && !nd[0]));
        n.pl = {(r[3] & m[1] & m[3]) | (r[2] & (m[2] | m[3])) | (r[1] & !m[2] & m[3]),
            r[1] & m[2], bad, r[0] & m[18] & r[10] & (r[12:11] == 2'h3),
            r[6] & m[16], r[9], r[8] & m[30]};
        if (frz) n.pl = '0;
        if (w && !bad && !frz) m = nd;
        if (r[5]) m[3] = 1'b1;
        else if (r[4]) m[3] = 1'b0;
        n.rd = l ? m : {32'h0, m[31:0]};
        n.lv = {m[0], m[31], !m[30], m[30] & m[31], r[13] & !r[14] & !m[5], r[13] & m[5]};
        wr <= w;
        wd <= d;
        lm <= l;
        evt <= r[3:0];
        clr <= r[4];
        tsw <= r[5];
        sup <= r[6];
        creq <= r[9:7];
        af <= r[10];
        priv <= r[12:11];
        pend <= r[13];
        ign <= r[14];
        ce <= !frz;
        q.push_back(n);
        @(posedge clk);
        wr <= 1'b0;
        evt <= '0;
        clr <= 1'b0;
        tsw <= 1'b0;
        sup <= 1'b0;
        creq <= '0;
        ce <= 1'b1;
    endtask : op

    // Clock, and a hang guard far above the ~720 cycles needed
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            fails++;
            print_verdict();
        end
    end

    // Watcher: pulses one edge after the request, levels one later
    initial begin
        mcr_note_t n;
        forever begin
            wait (q.size() > 0);
            n = q.pop_front();
            @(posedge clk);
            @(negedge clk);
            cmp_word(rd, n.rd);
            cmp_bits({flt, swb, crs, cwb}, n.pl);
            @(negedge clk);
            cmp_bits({1'b0, pon, pgon, cfe, pci, fpo, fpi}, {1'b0, n.lv});
        end
    end

    // Directed cases first, then seeded random traffic
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        op(0, 64'h0, 0, 0);
        op(1, 64'h0, 0, 0);
        op(1, 64'h8000_0000, 0, 0);
        op(1, 64'hffff_ffff_a000_0001, 0, 0);
        op(1, 64'h1_0000_0001, 1, 0);
        op(0, 64'h0, 0, 32'h20);
        op(0, 64'h0, 0, 32'h30);
        op(0, 64'h0, 0, 32'h10);
        op(1, m, 0, 0);
        op(0, 64'h0, 0, 0);
        // Frozen cycle: the write must not land and nothing may pulse
        frz = 1'b1;
        op(1, 64'h3, 0, 0);
        frz = 1'b0;
        $display("write and flag test done");
        for (int i = 0; i < 8; i++) begin
            op(1, {60'h0, i[2:0], 1'b0}, 0, 0);
            for (int j = 0; j < 4; j++) op(0, 64'h0, 0, 32'h1 << j);
        end
        for (int i = 0; i < 4; i++) op(1, {58'h0, i[1], 5'h0}, 0, {17'h0, i[0], 14'h2000});
        op(1, 64'hc005_0001, 0, 0);
        op(0, 64'h0, 0, 32'h1f41);
        $display("check and cache test done");
        for (int i = 0; i < 300; i++) begin
            s1 = xs(s0);
            s2 = xs(s1);
            s0 = xs(s2);
            op(s0[31], {s0[30] ? 32'h0 : s2, s1}, s0[29] & s0[28], s2);
        end
        $display("random test done");
        wait (q.size() == 0);
        repeat (3) @(posedge clk);
        print_verdict();
    end
endmodule : testbench

// *** src/mcr_cfg.svh ***
// Constants for the mode-control register block: bit positions,
// reset value and write-check masks.
// Assumes inclusion by the block's design file and its package only.
`ifndef MCR_CFG_SVH
`define MCR_CFG_SVH

// Field positions inside the 64-bit register
`define MCR_BIT_PROT_ON 0
`define MCR_BIT_WAIT_MON 1
`define MCR_BIT_EMUL 2
`define MCR_BIT_SWITCHED 3
`define MCR_BIT_TYPE 4
`define MCR_BIT_NUM_ERR 5
`define MCR_BIT_WR_GUARD 16
`define MCR_BIT_ALIGN_MASK 18
`define MCR_BIT_LEGACY_WT 29
`define MCR_BIT_FILL_OFF 30
`define MCR_BIT_XLATE 31

// Register width and the half kept by non-long-mode accesses
`define MCR_WIDTH 64
`define MCR_LOW_WIDTH 32

// Value after reset: only the fixed type flag is set
`define MCR_RESET_VAL 64'h0000_0000_0000_0010

// Bits that software can never clear
`define MCR_FORCED_ONES 64'h0000_0000_0000_0010

// Privilege level at which alignment faults apply
`define MCR_USER_PRIV 2'h3

`endif

// *** src/mcr_mode_ctl.sv ***
// Mode-control register with the execution, numeric-error, paging and
// cache checks that its bits steer.
// Assumes all inputs are synchronous to CORE_CLK and that the core
// presents each instruction or access event as a one-cycle pulse.
`timescale 1ns/1ps
`include "mcr_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
module mcr_mode_ctl
    import mcr_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // Register access by the move instructions
    input wire logic LONG_MODE,
    input wire logic WR_STROBE,
    input wire logic [63:0] WR_DATA,
    input wire logic CLEAR_SWITCHED,
    input wire logic TASK_SWITCH,
    output logic [63:0] RD_DATA,
    // Checks on executing instructions
    input wire mcr_exec_t EXEC_EVT,
    input wire logic ALIGN_CHECK_FLAG,
    input wire logic [1:0] CURRENT_PRIVILEGE,
    output mcr_fault_t FAULTS,
    // Numeric error routing
    input wire logic FP_EXC_PENDING,
    input wire logic FP_ERROR_IGNORE_IN,
    output logic FP_ERROR_OUT,
    output logic FP_EXC_INTERNAL,
    // Paging and protection
    input wire logic SUP_WRITE_RO_PAGE,
    output logic SUP_WRITE_BLOCK,
    output logic PROT_MODE_ON,
    output logic PAGING_ON,
    // Cache control
    input wire mcr_cache_req_t CACHE_REQ,
    output logic CACHE_FILL_EN,
    output logic CACHE_READ_SERVE,
    output logic CACHE_WB_INVALIDATE,
    output logic PAGE_CACHE_CTL_IGNORE
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state and write decision

    logic [63:0] mode_q;
    logic [63:0] mode_d;
    logic [63:0] wr_eff;
    mcr_wr_res_t wr_res;
    logic switched_d;

    // Field views of the stored register
    logic prot_on;
    logic wait_mon;
    logic emul;
    logic switched;
    logic num_err_int;
    logic wr_guard;
    logic align_mask;
    logic fill_off;
    logic xlate;

    assign prot_on = mode_q[`MCR_BIT_PROT_ON];
    assign wait_mon = mode_q[`MCR_BIT_WAIT_MON];
    assign emul = mode_q[`MCR_BIT_EMUL];
    assign switched = mode_q[`MCR_BIT_SWITCHED];
    assign num_err_int = mode_q[`MCR_BIT_NUM_ERR];
    assign wr_guard = mode_q[`MCR_BIT_WR_GUARD];
    assign align_mask = mode_q[`MCR_BIT_ALIGN_MASK];
    assign fill_off = mode_q[`MCR_BIT_FILL_OFF];
    assign xlate = mode_q[`MCR_BIT_XLATE];

    // Data as it would land: legacy writes zero the upper half
    always_comb begin
        if (LONG_MODE) begin
            wr_eff = WR_DATA;
        end else begin
            wr_eff = {32'h0000_0000, WR_DATA[31:0]};
        end
    end

    // Classify a write; both faults are judged on the landing value
    always_comb begin
        if (!WR_STROBE) begin
            wr_res = MCR_WR_IDLE;
        end else if (LONG_MODE && (WR_DATA[63:32] != 32'h0000_0000)) begin
            wr_res = MCR_WR_FAULT;
        end else if (wr_eff[`MCR_BIT_XLATE] && !wr_eff[`MCR_BIT_PROT_ON]) begin
            wr_res = MCR_WR_FAULT;
        end else begin
            wr_res = MCR_WR_TAKE;
        end
    end

    // Switched flag: task switch set beats any clear in the same cycle
    always_comb begin
        switched_d = switched;
        case (wr_res)
            MCR_WR_TAKE: switched_d = wr_eff[`MCR_BIT_SWITCHED];
            MCR_WR_IDLE: switched_d = switched;
            MCR_WR_FAULT: switched_d = switched;
            default: switched_d = switched;
        endcase
        if (CLEAR_SWITCHED) begin
            switched_d = 1'b0;
        end
        if (TASK_SWITCH) begin
            switched_d = 1'b1;
        end
    end

    // Next register value; reserved and legacy bits store as written
    always_comb begin
        mode_d = mode_q;
        case (wr_res)
            MCR_WR_TAKE: mode_d = wr_eff;
            MCR_WR_FAULT: mode_d = mode_q;
            MCR_WR_IDLE: mode_d = mode_q;
            default: mode_d = mode_q;
        endcase
        mode_d[`MCR_BIT_SWITCHED] = switched_d;
        mode_d = mode_d | `MCR_FORCED_ONES;
    end

    // Register update, frozen while the clock enable is low
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            mode_q <= `MCR_RESET_VAL;
        end else if (CLK_EN) begin
            mode_q <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back path

    // Registered so the output comes from a flop; tracks the next value
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            RD_DATA <= `MCR_RESET_VAL;
        end else if (CLK_EN) begin
            if (LONG_MODE) begin
                RD_DATA <= mode_d;
            end else begin
                RD_DATA <= {32'h0000_0000, mode_d[31:0]};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Instruction checks

    logic nm_d;
    logic ud_d;
    logic ac_d;

    // Emulation outranks the switched flag for media instructions
    always_comb begin
        nm_d = 1'b0;
        ud_d = 1'b0;
        if (EXEC_EVT.wait_op && wait_mon && switched) begin
            nm_d = 1'b1;
        end
        if (EXEC_EVT.fp_op && (emul || switched)) begin
            nm_d = 1'b1;
        end
        if (EXEC_EVT.media_op) begin
            if (emul) begin
                ud_d = 1'b1;
            end else if (switched) begin
                nm_d = 1'b1;
            end
        end
    end

    // Alignment check only at the least privileged level
    assign ac_d = EXEC_EVT.unaligned_ref && align_mask && ALIGN_CHECK_FLAG
                  && (CURRENT_PRIVILEGE == `MCR_USER_PRIV);

    // Fault pulses, one cycle after the triggering event
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            FAULTS <= '0;
        end else if (CLK_EN) begin
            FAULTS.device_unavailable_fault <= nm_d;
            FAULTS.invalid_opcode_fault <= ud_d;
            FAULTS.protection_fault <= (wr_res == MCR_WR_FAULT);
            FAULTS.alignment_fault <= ac_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Numeric error routing

    // External path only while internal handling is off
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            FP_ERROR_OUT <= 1'b0;
            FP_EXC_INTERNAL <= 1'b0;
        end else if (CLK_EN) begin
            FP_ERROR_OUT <= FP_EXC_PENDING && !num_err_int
                            && !FP_ERROR_IGNORE_IN;
            FP_EXC_INTERNAL <= FP_EXC_PENDING && num_err_int;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Protection and paging state

    // Mode levels follow the register with one flop of delay
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            PROT_MODE_ON <= 1'b0;
            PAGING_ON <= 1'b0;
            SUP_WRITE_BLOCK <= 1'b0;
        end else if (CLK_EN) begin
            PROT_MODE_ON <= prot_on;
            PAGING_ON <= xlate;
            SUP_WRITE_BLOCK <= SUP_WRITE_RO_PAGE && wr_guard;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Cache control

    // Fill permission and hit handling; misses with fills off change nothing
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            CACHE_FILL_EN <= 1'b0;
            CACHE_READ_SERVE <= 1'b0;
            CACHE_WB_INVALIDATE <= 1'b0;
            PAGE_CACHE_CTL_IGNORE <= 1'b0;
        end else if (CLK_EN) begin
            CACHE_FILL_EN <= !fill_off;
            CACHE_READ_SERVE <= CACHE_REQ.read_hit;
            CACHE_WB_INVALIDATE <= CACHE_REQ.write_hit && fill_off;
            PAGE_CACHE_CTL_IGNORE <= fill_off && xlate;
        end
    end

endmodule : mcr_mode_ctl

// *** src/mcr_pkg.sv ***
// Types shared by the mode-control register block and its bench.
// Assumes the constants header is available for widths.
`include "mcr_cfg.svh"

package mcr_pkg;

    // Instruction and memory events that the core presents for checking
    typedef struct packed {
        logic wait_op;
        logic fp_op;
        logic media_op;
        logic unaligned_ref;
    } mcr_exec_t;

    // Faults raised by the checks, one-cycle pulses
    typedef struct packed {
        logic device_unavailable_fault;
        logic invalid_opcode_fault;
        logic protection_fault;
        logic alignment_fault;
    } mcr_fault_t;

    // Cache-side requests
    typedef struct packed {
        logic read_hit;
        logic write_hit;
        logic miss;
    } mcr_cache_req_t;

    // Write-decision states for the register update path
    typedef enum logic [1:0] {
        MCR_WR_IDLE = 2'b00,
        MCR_WR_TAKE = 2'b01,
        MCR_WR_FAULT = 2'b10
    } mcr_wr_res_t;

endpackage : mcr_pkg
